// >>> inc/dpr_pkg.sv
// Purpose: Shared constants for the pattern register page store
// Assumes: Byte-wide locations, four pages of four locations each
// Notes:   Page and location codes follow the mode and bank-address fields
package dpr_pkg;

  // Store geometry
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned PAGE_W  = 2;
  localparam int unsigned LOC_W   = 2;
  localparam int unsigned N_LOC   = 4;
  localparam int unsigned UI_CNT  = 8;
  localparam int unsigned UI_W    = 3;

  // Page select codes from mode register 3 bits 1:0
  localparam logic [1:0] PAGE_PATTERN = 2'h0;
  localparam logic [1:0] PAGE_ERRLOG  = 2'h1;
  localparam logic [1:0] PAGE_MODE    = 2'h2;
  localparam logic [1:0] PAGE_VENDOR  = 2'h3;

  // Location codes from the bank-address bits
  localparam logic [1:0] LOC_0 = 2'h0;
  localparam logic [1:0] LOC_1 = 2'h1;
  localparam logic [1:0] LOC_2 = 2'h2;
  localparam logic [1:0] LOC_3 = 2'h3;

  // Page 0 power-up pattern values
  localparam logic [7:0] PAT_RESET [4] = '{8'h55, 8'h33, 8'h0F, 8'h00};

  // Refresh-mode field position and codes in page 2 location 0
  localparam int unsigned REF_LSB = 3;
  typedef enum logic [1:0] {
    DPR_REF_SUB1X = 2'h0,
    DPR_REF_1X    = 2'h1,
    DPR_REF_2X    = 2'h2,
    DPR_REF_RSVD  = 2'h3
  } dpr_refresh_t;

  // Activate-limit field width in page 3 location 3
  localparam int unsigned ACT_LIM_W = 4;

  // Value of a don't-care bit on readout
  localparam logic [7:0] DC_FILL = 8'h00;

endpackage

// >>> src/dpr_serializer.sv
// Purpose: Sends one stored byte out over eight unit intervals
// Assumes: One unit interval per clock; load restarts the burst
// Notes:   Bit 7 leaves first, bit 0 last
`timescale 1ns/100ps
`default_nettype none
module dpr_serializer (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [7:0] i_byte,
  output logic            o_bit,
  output logic            o_valid,
  output logic [2:0]      o_ui
);

  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [2:0] ui_q;
  logic [2:0] ui_d;
  logic       busy_q;
  logic       busy_d;
  logic       last_ui;

  // Next state of the shifter
  assign last_ui = (ui_q == 3'(dpr_pkg::UI_CNT - 1));
  assign shift_d = i_load ? i_byte : {shift_q[6:0], 1'b0};
  assign ui_d    = i_load ? 3'h0 : 3'(ui_q + 3'h1);
  assign busy_d  = i_load | (busy_q & ~last_ui);

  // Burst state
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= 8'h00;
      ui_q    <= 3'h0;
      busy_q  <= 1'b0;
    end else begin
      shift_q <= shift_d;
      ui_q    <= (busy_d) ? ui_d : 3'h0;
      busy_q  <= busy_d;
    end
  end

  // Output flops: MSB first
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bit   <= 1'b0;
      o_valid <= 1'b0;
      o_ui    <= 3'h0;
    end else begin
      o_bit   <= shift_d[7];
      o_valid <= busy_d;
      o_ui    <= ui_d;
    end
  end

  // Helper copy of the loaded byte for checking
  logic [7:0] snap_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      snap_q <= 8'h00;
    end else if (i_load) begin
      snap_q <= i_byte;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_load_quiet;
    i_load ##1 (!i_load) [*8];
  endsequence

  chk_ui_order: assert property (o_valid |-> o_bit == snap_q[3'(7 - int'(o_ui))])
    else $error("bit order on the lanes is wrong");
  chk_burst_len: assert property (i_load |=> o_valid [*8])
    else $error("burst shorter than eight intervals");
  chk_burst_end: assert property (s_load_quiet |=> !o_valid)
    else $error("burst longer than eight intervals");
  chk_first_ui: assert property (i_load |=> (o_ui == 3'h0 && o_bit == $past(i_byte[7])))
    else $error("first interval does not carry bit 7");

endmodule
`default_nettype wire

// >>> src/dpr_bank.sv
// Purpose: Four-page pattern register store with serial readout
// Assumes: All inputs come from logic on i_ref_clk
// Notes:   Read data appear one cycle after the read strobe
// Function
// - Address bit x lands in bit x; bit 7 first
// - Page 0 read/write with fixed power-up patterns
// - Page 2 location 1 returns reference-voltage training
// - Refresh field codes sub-1x, 1x, 2x, reserved
// - Page 3 don't-care except activate-limit nibble
// - Mode register page field routes every access
// - Page 0 keeps written data until reset
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dpr_bank #(
  parameter logic [3:0] ACT_LIMIT_CODE    = 4'h0,
  parameter logic       HARD_REPAIR_SUPP  = 1'b1,
  parameter logic       SOFT_REPAIR_SUPP  = 1'b1
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  // Access port
  input  wire logic [1:0]           i_page,
  input  wire logic [1:0]           i_loc,
  input  wire logic [7:0]           i_addr_bits,
  input  wire logic                 i_wr_stb,
  input  wire logic                 i_rd_stb,
  output logic      [7:0]           o_rdata,
  output logic                      o_rd_valid,
  output logic                      o_wr_refused,
  // Serial lane
  output logic                      o_dq_bit,
  output logic                      o_dq_valid,
  output logic      [2:0]           o_dq_ui,
  // Error frame capture
  input  wire logic                 i_err_capture,
  input  wire logic [17:0]          i_err_addr,
  input  wire logic                 i_err_act_n,
  input  wire logic [1:0]           i_err_bg,
  input  wire logic [1:0]           i_err_ba,
  input  wire logic                 i_err_par,
  input  wire logic [2:0]           i_err_cid,
  input  wire logic                 i_err_crc_flag,
  input  wire logic                 i_err_par_flag,
  input  wire logic [2:0]           i_par_latency,
  // Mode settings shown on page 2
  input  wire logic [6:0]           i_vref_train,
  input  wire dpr_pkg::dpr_refresh_t i_refresh_mode,
  input  wire logic                 i_temp_ok,
  input  wire logic                 i_crc_wr_en,
  input  wire logic [4:0]           i_cas_lat,
  input  wire logic [2:0]           i_wr_lat,
  input  wire logic [2:0]           i_rtt_nom,
  input  wire logic [2:0]           i_rtt_park,
  input  wire logic [1:0]           i_rtt_wr
);

  // Page 0 pattern storage and page 1 error log
  logic [7:0] pat_q [dpr_pkg::N_LOC];
  logic [7:0] err_q [dpr_pkg::N_LOC];
  logic [7:0] err_d [dpr_pkg::N_LOC];

  // Access decode
  wire pat_page  = (i_page == dpr_pkg::PAGE_PATTERN);
  wire wr_pat    = i_wr_stb & pat_page;
  wire wr_ro     = i_wr_stb & ~pat_page;

  // Next error log contents from the captured frame
  assign err_d[0] = i_err_addr[7:0];
  assign err_d[1] = {i_err_addr[15], i_err_addr[14], i_err_addr[13:8]};
  assign err_d[2] = {i_err_par, i_err_act_n, i_err_bg, i_err_ba,
                     i_err_addr[17], i_err_addr[16]};
  assign err_d[3] = {i_err_crc_flag, i_err_par_flag, i_par_latency, i_err_cid};

  // Per-location storage
  genvar gl;
  generate
    for (gl = 0; gl < dpr_pkg::N_LOC; gl++) begin : g_loc
      wire hit = (i_loc == 2'(gl));

      // Pattern byte: power-up default, then last write
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          pat_q[gl] <= dpr_pkg::PAT_RESET[gl];
        end else if (wr_pat && hit) begin
          pat_q[gl] <= i_addr_bits;
        end
      end

      // Error log byte: loaded only by a capture
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          err_q[gl] <= 8'h00;
        end else if (i_err_capture) begin
          err_q[gl] <= err_d[gl];
        end
      end
    end
  endgenerate

  // Page 2 readout bytes
  wire [7:0] mode_loc0 = {HARD_REPAIR_SUPP, SOFT_REPAIR_SUPP, 1'b0,
                          i_refresh_mode, i_temp_ok, 1'b0, i_crc_wr_en};
  wire [7:0] mode_loc1 = {i_vref_train[6], i_vref_train[5:0], 1'b0};
  wire [7:0] mode_loc2 = {i_cas_lat, i_wr_lat};
  wire [7:0] mode_loc3 = {i_rtt_nom, i_rtt_park, i_rtt_wr};

  // Page 3: only the activate-limit nibble is defined
  wire [7:0] vend_loc3 = {dpr_pkg::DC_FILL[7:4], ACT_LIMIT_CODE};

  // Per-page location select
  wire [7:0] pat_sel  = pat_q[i_loc];
  wire [7:0] err_sel  = err_q[i_loc];
  wire [7:0] mode_sel = (i_loc == dpr_pkg::LOC_0) ? mode_loc0 :
                        (i_loc == dpr_pkg::LOC_1) ? mode_loc1 :
                        (i_loc == dpr_pkg::LOC_2) ? mode_loc2 : mode_loc3;
  wire [7:0] vend_sel = (i_loc == dpr_pkg::LOC_3) ? vend_loc3 : dpr_pkg::DC_FILL;

  // Page routing from the mode register field
  wire [7:0] rd_sel = (i_page == dpr_pkg::PAGE_PATTERN) ? pat_sel  :
                      (i_page == dpr_pkg::PAGE_ERRLOG)  ? err_sel  :
                      (i_page == dpr_pkg::PAGE_MODE)    ? mode_sel : vend_sel;

  // Read data and status flops
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata      <= 8'h00;
      o_rd_valid   <= 1'b0;
      o_wr_refused <= 1'b0;
    end else begin
      o_rdata      <= i_rd_stb ? rd_sel : 8'h00;
      o_rd_valid   <= i_rd_stb;
      o_wr_refused <= wr_ro;
    end
  end

  // Lane serializer, loaded by each read
  dpr_serializer u_ser (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (i_rd_stb),
    .i_byte    (rd_sel),
    .o_bit     (o_dq_bit),
    .o_valid   (o_dq_valid),
    .o_ui      (o_dq_ui)
  );

  // Flat view of the pattern bytes for the hold checks
  wire [31:0] pat_flat = {pat_q[3], pat_q[2], pat_q[1], pat_q[0]};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_pat_write;
    i_wr_stb && i_page == dpr_pkg::PAGE_PATTERN;
  endsequence

  sequence s_rd_mode_loc1;
    i_rd_stb && i_page == dpr_pkg::PAGE_MODE && i_loc == dpr_pkg::LOC_1;
  endsequence

  chk_pat_write: assert property (s_pat_write |=> pat_q[$past(i_loc)] == $past(i_addr_bits))
    else $error("pattern write not stored");
  chk_pat_hold: assert property (!(i_wr_stb && pat_page) |=> pat_flat == $past(pat_flat))
    else $error("pattern bytes changed without a write");
  chk_ro_ignored: assert property (wr_ro |=> (pat_flat == $past(pat_flat) && o_wr_refused))
    else $error("write to read-only page had an effect");
  chk_page_route: assert property (i_rd_stb && i_page == dpr_pkg::PAGE_PATTERN
                                   |=> o_rdata == $past(pat_q[i_loc]) && o_rd_valid)
    else $error("page 0 read returned the wrong byte");
  chk_vref_readout: assert property (s_rd_mode_loc1 |=> o_rdata[7:1] == $past(i_vref_train))
    else $error("training readout mismatch");
  chk_refresh_field: assert property (i_rd_stb && i_page == dpr_pkg::PAGE_MODE && i_loc == dpr_pkg::LOC_0
                                      |=> o_rdata[4:3] == $past(i_refresh_mode))
    else $error("refresh field mismatch");
  chk_act_limit: assert property (i_rd_stb && i_page == dpr_pkg::PAGE_VENDOR && i_loc == dpr_pkg::LOC_3
                                  |=> o_rdata[3:0] == ACT_LIMIT_CODE)
    else $error("activate-limit nibble mismatch");
  chk_err_capture: assert property (i_err_capture |=> err_q[2] == $past(err_d[2])
                                    && err_q[3] == $past(err_d[3]))
    else $error("error frame not captured");
  chk_err_readback: assert property (i_rd_stb && i_page == dpr_pkg::PAGE_ERRLOG
                                     |=> o_rdata == $past(err_q[i_loc]))
    else $error("error log read mismatch");

endmodule
`default_nettype wire

// >>> test/dpr_ctrl_model.sv
// Purpose: Controller side receiver for the pattern register serial lane
// Assumes: One unit interval per clock, sampled on the rising edge
// Notes:   Rebuilds the byte with the first interval landing in bit 7
`timescale 1ns/100ps
`default_nettype none
module dpr_ctrl_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_dq_bit,
  input  wire logic       i_dq_valid,
  input  wire logic [2:0] i_dq_ui,
  output logic      [7:0] o_byte,
  output logic            o_done
);
  // Shift lane bits in, earliest interval ends in the top bit
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_byte <= 8'h00;
      o_done <= 1'h0;
    end else if (i_dq_valid) begin
      o_byte <= {o_byte[6:0], i_dq_bit};
      o_done <= (i_dq_ui == 3'h7);
    end
  end
endmodule
`default_nettype wire

// >>> test/dpr_bank_tb.sv
// Purpose: Self-checking bench for the pattern register page store
// Assumes: Bench drives the controller side at rising edges
// Notes:   Expected bytes come from a small array model in the bench
`timescale 1ns/100ps
`default_nettype none
module dpr_bank_tb;
  localparam logic [3:0] ACT_CODE = 4'hA;
  logic                  i_ref_clk, i_rst, i_wr_stb, i_rd_stb, i_err_capture;
  logic [1:0]            i_page, i_loc, i_err_bg, i_err_ba, i_rtt_wr;
  logic [7:0]            i_addr_bits, o_rdata, ser_byte;
  logic [17:0]           i_err_addr;
  logic                  i_err_act_n, i_err_par, i_err_crc_flag, i_err_par_flag, i_temp_ok, i_crc_wr_en;
  logic [2:0]            i_err_cid, i_par_latency, i_wr_lat, i_rtt_nom, i_rtt_park, o_dq_ui;
  logic [6:0]            i_vref_train;
  logic [4:0]            i_cas_lat;
  dpr_pkg::dpr_refresh_t i_refresh_mode;
  logic                  o_rd_valid, o_wr_refused, o_dq_bit, o_dq_valid, ser_done;
  logic [7:0]            pat [4];
  logic [7:0]            elog [4];
  int                    num_errors, checks_done, cycles;

  dpr_bank #(.ACT_LIMIT_CODE(ACT_CODE)) u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_page(i_page),
    .i_loc(i_loc), .i_addr_bits(i_addr_bits), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid), .o_wr_refused(o_wr_refused), .o_dq_bit(o_dq_bit), .o_dq_valid(o_dq_valid),
    .o_dq_ui(o_dq_ui), .i_err_capture(i_err_capture), .i_err_addr(i_err_addr), .i_err_act_n(i_err_act_n),
    .i_err_bg(i_err_bg), .i_err_ba(i_err_ba), .i_err_par(i_err_par), .i_err_cid(i_err_cid),
    .i_err_crc_flag(i_err_crc_flag), .i_err_par_flag(i_err_par_flag), .i_par_latency(i_par_latency),
    .i_vref_train(i_vref_train), .i_refresh_mode(i_refresh_mode), .i_temp_ok(i_temp_ok),
    .i_crc_wr_en(i_crc_wr_en), .i_cas_lat(i_cas_lat), .i_wr_lat(i_wr_lat), .i_rtt_nom(i_rtt_nom),
    .i_rtt_park(i_rtt_park), .i_rtt_wr(i_rtt_wr));
  dpr_ctrl_model u_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_dq_bit(o_dq_bit), .i_dq_valid(o_dq_valid),
    .i_dq_ui(o_dq_ui), .o_byte(ser_byte), .o_done(ser_done));

  // Clock generator
  initial begin
    i_ref_clk = 1'h0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // Hang guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Random error frame and mode settings
  task automatic env_rand();
    logic [31:0] r;
    r = $urandom;
    {i_err_addr, i_err_act_n, i_err_bg, i_err_ba, i_err_par} <= r[23:0];
    r = $urandom;
    {i_err_cid, i_err_crc_flag, i_err_par_flag, i_par_latency, i_vref_train} <= r[14:0];
    i_refresh_mode <= dpr_pkg::dpr_refresh_t'(r[16:15]);
    r = $urandom;
    {i_temp_ok, i_crc_wr_en, i_cas_lat, i_wr_lat, i_rtt_nom, i_rtt_park, i_rtt_wr} <= r[17:0];
  endtask

  task automatic wr(input logic [1:0] pg, input logic [1:0] lc, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_page <= pg;
    i_loc <= lc;
    i_addr_bits <= d;
    i_wr_stb <= 1'h1;
    @(posedge i_ref_clk);
    i_wr_stb <= 1'h0;
    #1;
    chk("wr_refused", {7'h00, pg != 2'h0}, {7'h00, o_wr_refused});
  endtask

  // Read, then compare parallel byte and the rebuilt serial byte
  task automatic rdx(input logic [1:0] pg, input logic [1:0] lc, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge i_ref_clk);
    i_page <= pg;
    i_loc <= lc;
    i_rd_stb <= 1'h1;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'h0;
    #1;
    chk("rd_valid", 8'h01, {7'h00, o_rd_valid});
    chk("rdata", exp & msk, o_rdata & msk);
    repeat (8) @(posedge i_ref_clk);
    #1;
    chk("serial", exp & msk, ser_byte & msk);
    chk("serial_done", 8'h01, {7'h00, ser_done});
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    void'($urandom(20288));
    {i_wr_stb, i_rd_stb, i_err_capture, i_page, i_loc, i_addr_bits} = 15'h0000;
    env_rand();
    pat = '{8'h55, 8'h33, 8'h0F, 8'h00};
    i_rst = 1'h1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    for (int k = 0; k < 4; k++) rdx(2'h0, k[1:0], pat[k], 8'hFF);
    @(posedge i_ref_clk);
    env_rand();
    i_err_capture <= 1'h1;
    @(posedge i_ref_clk);
    i_err_capture <= 1'h0;
    elog[0] = i_err_addr[7:0];
    elog[1] = i_err_addr[15:8];
    elog[2] = {i_err_par, i_err_act_n, i_err_bg, i_err_ba, i_err_addr[17:16]};
    elog[3] = {i_err_crc_flag, i_err_par_flag, i_par_latency, i_err_cid};
    for (int n = 0; n < 16; n++) begin
      r = $urandom;
      wr(r[1:0], r[3:2], r[11:4]);
      if (r[1:0] == 2'h0) pat[r[3:2]] = r[11:4];
      rdx(2'h0, r[3:2], pat[r[3:2]], 8'hFF);
    end
    for (int k = 0; k < 4; k++) rdx(2'h1, k[1:0], elog[k], 8'hFF);
    for (int k = 0; k < 4; k++) rdx(2'h0, k[1:0], pat[k], 8'hFF);
    rdx(2'h2, 2'h1, {i_vref_train, 1'h0}, 8'hFF);
    rdx(2'h2, 2'h2, {i_cas_lat, i_wr_lat}, 8'hFF);
    rdx(2'h2, 2'h3, {i_rtt_nom, i_rtt_park, i_rtt_wr}, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_ref_clk);
      i_refresh_mode <= dpr_pkg::dpr_refresh_t'(k[1:0]);
      rdx(2'h2, 2'h0, {2'h3, 1'h0, k[1:0], i_temp_ok, 1'h0, i_crc_wr_en}, 8'hFF);
    end
    rdx(2'h3, 2'h3, {4'h0, ACT_CODE}, 8'h0F);
    // Mid-run reset brings back the power-up patterns and clears the log
    @(posedge i_ref_clk);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    pat = '{8'h55, 8'h33, 8'h0F, 8'h00};
    for (int k = 0; k < 4; k++) rdx(2'h0, k[1:0], pat[k], 8'hFF);
    rdx(2'h1, 2'h0, 8'h00, 8'hFF);
    end_of_test();
  end
endmodule
`default_nettype wire
